// File: logic/window_watchdog_pkg.sv
/*
  Constants and field layouts shared by the window watchdog.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
`default_nettype none

package window_watchdog_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_WATCHDOG_CONTROL = 4'h0;
  localparam logic [3:0] OFS_WATCHDOG_CONFIG = 4'h4;
  localparam logic [3:0] OFS_WATCHDOG_FLAGS = 4'h8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned POS_ACTIVATION_BIT = 7;
  localparam int unsigned POS_COUNT_TOP_BIT = 6;
  localparam int unsigned POS_EARLY_WARN_ENABLE = 9;
  localparam int unsigned POS_TIMEBASE_LSB = 7;
  localparam int unsigned POS_EARLY_WARN_FLAG = 0;

  // ----------------------------------------------------------------
  // Reset values and counter landmarks
  // ----------------------------------------------------------------
  localparam logic [6:0] RST_COUNT = 7'h7F;
  localparam logic [6:0] RST_WINDOW = 7'h7F;
  localparam logic [1:0] RST_TIMEBASE = 2'h0;
  localparam logic [6:0] CNT_WARN = 7'h40;
  localparam logic [6:0] CNT_BEFORE_WARN = 7'h41;

  // ----------------------------------------------------------------
  // Timing: fixed divider of 4096 bus clocks, as a power of two
  // ----------------------------------------------------------------
  localparam int unsigned BASE_DIV_LOG2_DEFAULT = 12;
  localparam int unsigned TIMEBASE_MAX_LOG2 = 3;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Configuration fields travelling together
  typedef struct packed {
    logic early_warn_enable;
    logic [1:0] timebase_select;
    logic [6:0] window;
  } watchdog_config_t;

endpackage : window_watchdog_pkg

`default_nettype wire

// File: logic/window_watchdog.sv
/*
  Window watchdog with an AXI4-Lite register slave.
  Assumes one clock (aclk), a synchronous active-low reset, and a system
  reset controller that acts on the one-cycle reset request pulse.
  The debug halt inputs come from logic on the same clock.
*/
// Contract
// - Active watchdog requests reset when count steps from 0x40 to 0x3F.
// - Active watchdog requests reset on refresh while count exceeds window.
// - Inactive after reset; writing one activates; only reset deactivates.
// - Counter decrements at prescaled rate even when inactive.
// - Only refresh at or below window and above 0x3F avoids reset.
// - Writing activation one with top bit zero forces immediate reset.
// - Early warning interrupt when enabled and count reaches 0x40.
// - Writing zero to the early warning flag clears it.
// - Decrement every 4096 times two-to-timebase bus clocks.
// - Timebase select 0..3 divides the 4096 tick by 1,2,4,8.
// - Control writes do not clear the prescaler.
// - Debug halt freezes counting when freeze control is set.
// - Flag sets at 0x40 even if disabled; writing one ignored.
// - Early warning enable set by software, cleared only by reset.
// - Control register resets to 0x7F.
`timescale 1ns/100ps
`default_nettype none

module window_watchdog
  import window_watchdog_pkg::*;
#(
  parameter int unsigned BASE_DIV_LOG2 = BASE_DIV_LOG2_DEFAULT
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Debug halt
  input wire logic core_halted,
  input wire logic debug_halt_freeze,
  // Toward system
  output logic reset_request,
  output logic early_warn_irq
);

  localparam int unsigned PW = BASE_DIV_LOG2 + TIMEBASE_MAX_LOG2;

  initial begin
    if (BASE_DIV_LOG2 < 1 || BASE_DIV_LOG2 > 24) begin
      $error("BASE_DIV_LOG2 out of range");
    end
  end

  // ----------------------------------------------------------------
  // Register decode helpers
  // ----------------------------------------------------------------
  // Word select: low nibble of address with byte bits cleared
  function automatic logic [3:0] word_ofs(input logic [31:0] a);
    word_ofs = {a[3:2], 2'b00};
  endfunction : word_ofs

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a[31:4] == 28'h000_0000) && (word_ofs(a) != 4'hC);
  endfunction : mapped

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] aw_addr_q, w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic activation_q, flag_q, irq_q, reset_req_q;
  logic [6:0] count_q;
  watchdog_config_t cfg_q;
  logic [PW-1:0] presc_q;

  // ----------------------------------------------------------------
  // Bus write path
  // ----------------------------------------------------------------
  logic wr_go, aw_have_d, w_have_d, wr_half, wr_ctrl, wr_cfg, wr_flags;
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign aw_have_d = wr_go ? 1'b0 : (aw_have_q || (awvalid && awready_q));
  assign w_have_d = wr_go ? 1'b0 : (w_have_q || (wvalid && wready_q));
  // Byte writes are ignored; half-word or word lanes 0 and 1 needed
  assign wr_half = (w_strb_q[1:0] == 2'b11);
  assign wr_ctrl = wr_go && wr_half && mapped(aw_addr_q) && (word_ofs(aw_addr_q) == OFS_WATCHDOG_CONTROL);
  assign wr_cfg = wr_go && wr_half && mapped(aw_addr_q) && (word_ofs(aw_addr_q) == OFS_WATCHDOG_CONFIG);
  assign wr_flags = wr_go && wr_half && mapped(aw_addr_q) && (word_ofs(aw_addr_q) == OFS_WATCHDOG_FLAGS);

  // Address and data capture, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= !aw_have_d;
      wready_q <= !w_have_d;
      if (awvalid && awready_q) begin
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
    end
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bus read path
  // ----------------------------------------------------------------
  logic ar_take, rvalid_d;
  logic [31:0] rd_word;
  assign ar_take = arvalid && arready_q;
  assign rvalid_d = ar_take || (rvalid_q && !rready);

  // Read multiplexer, reserved bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (word_ofs(araddr))
      OFS_WATCHDOG_CONTROL: rd_word = {24'h00_0000, activation_q, count_q};
      OFS_WATCHDOG_CONFIG: rd_word = {22'h00_0000, cfg_q};
      OFS_WATCHDOG_FLAGS: rd_word = {31'h0000_0000, flag_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read data, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      arready_q <= !rvalid_d;
      if (ar_take) begin
        rdata_q <= mapped(araddr) ? rd_word : 32'h0000_0000;
        rresp_q <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and down-counter
  // ----------------------------------------------------------------
  logic freeze, tick;
  logic [PW-1:0] tick_mask;
  assign freeze = core_halted && debug_halt_freeze;
  // Low BASE_DIV_LOG2 + select bits all ones marks one counter step
  assign tick_mask = PW'((1 << (BASE_DIV_LOG2 + 32'(cfg_q.timebase_select))) - 1);
  assign tick = !freeze && ((presc_q & tick_mask) == tick_mask);

  // Free-running prescaler, never cleared by register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= '0;
    end else if (!freeze) begin
      presc_q <= presc_q + PW'(1);
    end
  end

  // Counter: refresh by write, else step down on each tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= RST_COUNT;
    end else if (wr_ctrl) begin
      count_q <= w_data_q[6:0];
    end else if (tick) begin
      count_q <= count_q - 7'h01;
    end
  end

  // Activation bit: set by software, cleared only by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      activation_q <= 1'b0;
    end else if (wr_ctrl && w_data_q[POS_ACTIVATION_BIT]) begin
      activation_q <= 1'b1;
    end
  end

  // Configuration: window, timebase, sticky early-warning enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= '{early_warn_enable: 1'b0, timebase_select: RST_TIMEBASE, window: RST_WINDOW};
    end else if (wr_cfg) begin
      cfg_q.window <= w_data_q[6:0];
      cfg_q.timebase_select <= w_data_q[POS_TIMEBASE_LSB +: 2];
      cfg_q.early_warn_enable <= cfg_q.early_warn_enable || w_data_q[POS_EARLY_WARN_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // Reset request
  // ----------------------------------------------------------------
  logic cause_underflow, cause_window, cause_forced, reset_cause;
  assign cause_underflow = activation_q && tick && !wr_ctrl && (count_q == CNT_WARN);
  assign cause_window = wr_ctrl && activation_q && (count_q > cfg_q.window);
  assign cause_forced = wr_ctrl && (activation_q || w_data_q[POS_ACTIVATION_BIT])
    && !w_data_q[POS_COUNT_TOP_BIT];
  assign reset_cause = cause_underflow || cause_window || cause_forced;

  // One-cycle registered pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= reset_cause;
    end
  end

  // ----------------------------------------------------------------
  // Early warning flag and interrupt
  // ----------------------------------------------------------------
  logic flag_set, flag_d;
  assign flag_set = tick && !wr_ctrl && (count_q == CNT_BEFORE_WARN);
  // Set wins over a clear in the same cycle; writing one is ignored
  assign flag_d = flag_set || (flag_q && !(wr_flags && !w_data_q[POS_EARLY_WARN_FLAG]));

  // Flag and interrupt output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      irq_q <= flag_d && (cfg_q.early_warn_enable || (wr_cfg && w_data_q[POS_EARLY_WARN_ENABLE]));
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign reset_request = reset_req_q;
  assign early_warn_irq = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_underflow_reset: assert property (cause_underflow |=> reset_req_q)
    else $error("underflow did not request reset");
  a_window_reset: assert property ((wr_ctrl && activation_q && count_q > cfg_q.window) |=> reset_req_q)
    else $error("early refresh did not request reset");
  a_act_sticky: assert property (activation_q |=> activation_q)
    else $error("activation bit cleared without reset");
  a_free_running: assert property ((tick && !wr_ctrl) |=> count_q == 7'($past(count_q) - 7'h01))
    else $error("counter failed to decrement");
  a_no_spurious: assert property ((!activation_q && !wr_ctrl) |=> !reset_req_q)
    else $error("reset requested while inactive");
  a_forced_reset: assert property ((wr_ctrl && w_data_q[7] && !w_data_q[6]) |=> reset_req_q)
    else $error("forced reset missing");
  a_warn_irq: assert property ((flag_set && cfg_q.early_warn_enable) |=> flag_q && irq_q)
    else $error("early warning interrupt missing");
  a_flag_clear: assert property ((wr_flags && !w_data_q[0] && !flag_set) |=> !flag_q && !irq_q)
    else $error("flag not cleared");
  a_step_on_tick: assert property ((!tick && !wr_ctrl) |=> $stable(count_q))
    else $error("counter moved between ticks");
  a_freeze_hold: assert property ((freeze && !wr_ctrl) |=> $stable(count_q))
    else $error("counter moved while frozen");
  a_enable_sticky: assert property (cfg_q.early_warn_enable |=> cfg_q.early_warn_enable)
    else $error("early warning enable cleared");
  a_irq_level: assert property (irq_q |-> $past(flag_d))
    else $error("interrupt without flag");

  c_underflow: cover property (cause_underflow ##1 reset_req_q);
  c_window: cover property (cause_window);
  c_good_refresh: cover property (wr_ctrl && activation_q && !reset_cause);
  c_warning: cover property (flag_set && cfg_q.early_warn_enable);

endmodule : window_watchdog

`default_nettype wire

// File: testbench/window_watchdog_tb.sv
/*
  Self-checking bench for the window watchdog, driving its AXI4-Lite port.
  Assumes the divider is shortened to 4 clocks, so one count step takes 4 << timebase clocks.
*/
`timescale 1ns/100ps
`default_nettype none

module window_watchdog_tb import window_watchdog_pkg::*; ();
  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  localparam int unsigned DIV_LOG2 = 2;
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] val;
    logic [1:0] resp;
  } note_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic core_halted = 1'b1;
  logic debug_halt_freeze = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, reset_request, early_warn_irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd_val;
  logic [31:0] seed = 32'h0000_0054;
  note_t rq[$];
  note_t note;
  logic [1:0] bq[$];
  int failures = 0, num_checks = 0, pulses = 0, pulse_cyc = 0, cyc = 0, n = 0;

  window_watchdog #(.BASE_DIV_LOG2(DIV_LOG2)) window_watchdog_i (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .core_halted(core_halted), .debug_halt_freeze(debug_halt_freeze),
    .reset_request(reset_request), .early_warn_irq(early_warn_irq)
  );

  // Clock at 40 MHz
  always #12.5 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xorshift

  task automatic final_report;
    $display("Checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_up(input string what);
    failures++;
    $display("Error %s expected handshake seen none", what);
    final_report();
  endtask : give_up

  task automatic idle(input int c);
    repeat (c) @(posedge aclk);
    @(negedge aclk);
  endtask : idle

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    pulses = 0;
  endtask : do_reset

  // Write: address and data offered together, response awaited
  task automatic wr(input logic [31:0] addr, input logic [31:0] data, input logic [3:0] strb, input logic [1:0] resp);
    int i;
    @(posedge aclk);
    bq.push_back(resp);
    awaddr <= addr;
    wdata <= data;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (i == 50) give_up("write");
  endtask : wr

  // Read: expectation noted, data kept for the caller
  task automatic rd(input logic [31:0] addr, input logic [31:0] mask, input logic [31:0] val, input logic [1:0] resp);
    int i;
    @(posedge aclk);
    rq.push_back('{mask, val, resp});
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rd_val = rdata;
    if (i == 50) give_up("read");
  endtask : rd

  // Output watcher: pulse log and comparison of notes
  always @(posedge aclk) begin
    cyc++;
    if (aresetn && reset_request === 1'b1) begin
      pulses++;
      pulse_cyc = cyc;
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      note = rq.pop_front();
      check(rdata & note.mask, note.val, "read data");
      check({30'h0, rresp}, {30'h0, note.resp}, "read response");
    end
    if (bvalid === 1'b1 && bready === 1'b1) check({30'h0, bresp}, {30'h0, bq.pop_front()}, "write response");
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    // Frozen counter: reset values, unmapped place, byte write
    do_reset();
    rd(32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_007F, RESP_OKAY);
    rd(32'h0000_0004, 32'hFFFF_FFFF, 32'h0000_007F, RESP_OKAY);
    rd(32'h0000_0008, 32'hFFFF_FFFF, 32'h0000_0000, RESP_OKAY);
    rd(32'h0000_000C, 32'hFFFF_FFFF, 32'h0000_0000, RESP_SLVERR);
    wr(32'h0000_000C, 32'h0000_00FF, 4'hF, RESP_SLVERR);
    wr(32'h0000_0004, 32'h0000_0000, 4'h1, RESP_OKAY);
    rd(32'h0000_0004, 32'hFFFF_FFFF, 32'h0000_007F, RESP_OKAY);
    rd(32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_007F, RESP_OKAY);
    // Running while inactive once the halt freeze is lifted
    @(posedge aclk);
    debug_halt_freeze <= 1'b0;
    idle(40);
    rd(32'h0000_0000, 32'h0000_0080, 32'h0000_0000, RESP_OKAY);
    check(32'(rd_val[6:0] < 7'h7F), 1, "free count");
    check(pulses, 0, "inactive pulses");
    // Forced reset by clearing the top count bit
    wr(32'h0000_0000, 32'h0000_00BF, 4'hF, RESP_OKAY);
    idle(2);
    check(pulses, 1, "forced pulse");
    // Refresh above the window; core running, so freeze control must not stop counting
    do_reset();
    core_halted <= 1'b0;
    debug_halt_freeze <= 1'b1;
    wr(32'h0000_0004, 32'h0000_0050, 4'hF, RESP_OKAY);
    wr(32'h0000_0000, 32'h0000_00FF, 4'hF, RESP_OKAY);
    idle(1);
    check(pulses, 0, "activation pulse");
    wr(32'h0000_0000, 32'h0000_00FF, 4'hF, RESP_OKAY);
    idle(2);
    check(pulses, 1, "early refresh pulse");
    // Random refreshes inside the window, then a try at deactivation
    do_reset();
    wr(32'h0000_0000, 32'h0000_00FF, 4'hF, RESP_OKAY);
    repeat (8) begin
      idle(8);
      seed = xorshift(seed);
      wr(32'h0000_0000, 32'h0000_00C8 | {26'h0, seed[5:0]}, 4'hF, RESP_OKAY);
    end
    idle(8);
    wr(32'h0000_0000, 32'h0000_007F, 4'hF, RESP_OKAY);
    rd(32'h0000_0000, 32'h0000_0080, 32'h0000_0080, RESP_OKAY);
    check(pulses, 0, "window refresh pulses");
    // Timeout per timebase, early warning and its flag
    for (int t = 0; t < 4; t++) begin
      do_reset();
      wr(32'h0000_0004, {22'h0, t == 0, t[1:0], 7'h7F}, 4'hF, RESP_OKAY);
      wr(32'h0000_0000, 32'h0000_00FF, 4'hF, RESP_OKAY);
      idle(0);
      n = cyc;
      idle(70 * (4 << t));
      check(pulses, 1, "timeout pulses");
      check(32'(pulse_cyc - n >= 63 * (4 << t) - 4 && pulse_cyc - n <= 64 * (4 << t) + 4), 1, "timeout span");
      check({31'h0, early_warn_irq}, 32'(t == 0), "warn irq");
      wr(32'h0000_0008, 32'h0000_0001, 4'hF, RESP_OKAY);
      rd(32'h0000_0008, 32'hFFFF_FFFF, 32'h0000_0001, RESP_OKAY);
      wr(32'h0000_0008, 32'h0000_0000, 4'hF, RESP_OKAY);
      rd(32'h0000_0008, 32'hFFFF_FFFF, 32'h0000_0000, RESP_OKAY);
      idle(1);
      check({31'h0, early_warn_irq}, 0, "warn irq cleared");
      wr(32'h0000_0004, {22'h0, 1'b0, t[1:0], 7'h7F}, 4'hF, RESP_OKAY);
      rd(32'h0000_0004, 32'hFFFF_FFFF, {22'h0, t == 0, t[1:0], 7'h7F}, RESP_OKAY);
    end
    final_report();
  end
endmodule : window_watchdog_tb

`default_nettype wire
